// File: hw/vfd_regs.vh
// constants for the video frame delay pipeline
`ifndef VFD_REGS_VH
`define VFD_REGS_VH

// ==========================================================
// source kinds (processing scenario select)
`define VFD_KIND_ASYNC_UP   3'h0
`define VFD_KIND_SYNC_GFX   3'h1
`define VFD_KIND_ASYNC_DN   3'h2
`define VFD_KIND_SYNC_UPV   3'h3
`define VFD_KIND_SYNC_VID   3'h4
`define VFD_KIND_FS3D       3'h5

// ==========================================================
// byte modes of the serial video input
`define VFD_BYTE_MODE_3     2'h1
`define VFD_BYTE_MODE_4     2'h2
`define VFD_BYTE_MODE_5     2'h3

// ==========================================================
// resolution limits
`define VFD_MIN_H_2D        13'h0280
`define VFD_MIN_V_2D        13'h01E0
`define VFD_MAX_H_2D        13'h1000
`define VFD_MAX_V_2D        13'h0870
`define VFD_MAX_H_3D        13'h0780
`define VFD_MAX_V_3D        13'h0438

// ==========================================================
// component widths and field positions
`define VFD_COMP_IN_W       12
`define VFD_COMP_OUT_W      10
`define VFD_DROP_LSB        2

// ==========================================================
// stage delays in frames
`define VFD_DEI_FRAMES      8'h01
`define VFD_FRC_FRAMES      8'h01
`define VFD_FMT_SYNC_FRAMES 8'h01

`endif

// File: hw/vfd_pipe.v
// video input acceptance and frame latency control
`timescale 1ns/100ps
`default_nettype none
`include "vfd_regs.vh"

module vfd_pipe #(
  parameter RATIO_W = 4
) (
  input  wire                mclk,
  input  wire                rstn,
  input  wire                sync_clear,
  input  wire [2:0]          src_kind,
  input  wire [1:0]          byte_mode,
  input  wire                deep_color,
  input  wire [RATIO_W-1:0]  ratio_n,
  input  wire [RATIO_W-1:0]  ratio_m,
  input  wire                vid_valid,
  output reg                 vid_ready,
  input  wire [35:0]         vid_data,
  input  wire                vid_sof,
  input  wire                vid_eol,
  output reg                 pix_valid,
  input  wire                pix_ready,
  output reg  [29:0]         pix_data,
  output reg                 pix_sof,
  output reg                 pix_eol,
  output reg  [7:0]          latency_frames,
  output reg                 deinterlacer_on,
  output reg                 frame_rate_converter_on,
  output reg                 video_live,
  output reg                 out_frame_start,
  output reg                 res_error,
  output reg                 mode_error
);

  // ==========================================================
  // stage delay decode
  function [7:0] dei_frames;
    input [2:0] kind;
    begin
      case (kind)
        `VFD_KIND_SYNC_UPV: dei_frames = `VFD_DEI_FRAMES;
        `VFD_KIND_SYNC_VID: dei_frames = `VFD_DEI_FRAMES;
        default:            dei_frames = 8'h00;
      endcase
    end
  endfunction

  function [7:0] fmt_frames;
    input [2:0]         kind;
    input [RATIO_W-1:0] n;
    input [RATIO_W-1:0] m;
    begin
      case (kind)
        `VFD_KIND_ASYNC_UP: fmt_frames = {{(8-RATIO_W){1'b0}}, n};
        `VFD_KIND_ASYNC_DN: fmt_frames = {{(8-RATIO_W){1'b0}}, n};
        `VFD_KIND_SYNC_UPV: fmt_frames = {{(8-RATIO_W){1'b0}}, n};
        `VFD_KIND_FS3D:     fmt_frames = {{(8-RATIO_W){1'b0}}, m};
        default:            fmt_frames = `VFD_FMT_SYNC_FRAMES;
      endcase
    end
  endfunction

  function kind_ok;
    input [2:0] kind;
    begin
      kind_ok = (kind <= `VFD_KIND_FS3D);
    end
  endfunction

  // ==========================================================
  // input acceptance and component truncation
  wire        acc = vid_valid & vid_ready;
  wire [29:0] trunc_data;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_comp
      assign trunc_data[gi*10 +: 10] = deep_color ?
        vid_data[gi*12 + `VFD_DROP_LSB +: `VFD_COMP_OUT_W] :
        vid_data[gi*12 +: `VFD_COMP_OUT_W];
    end
  endgenerate

  // ==========================================================
  // frame size measurement
  reg  [12:0] hcount;
  reg  [12:0] line_len;
  reg  [12:0] vcount;
  reg         seen_frame;
  wire        frame_done = acc & vid_sof & seen_frame;
  wire        is_3d      = (src_kind == `VFD_KIND_FS3D);
  wire        size_bad   = is_3d ?
    ((line_len > `VFD_MAX_H_3D) | (vcount > `VFD_MAX_V_3D)) :
    ((line_len < `VFD_MIN_H_2D) | (line_len > `VFD_MAX_H_2D) |
     (vcount < `VFD_MIN_V_2D) | (vcount > `VFD_MAX_V_2D));

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hcount     <= 13'h0000;
      line_len   <= 13'h0000;
      vcount     <= 13'h0000;
      seen_frame <= 1'b0;
      res_error  <= 1'b0;
    end else if (sync_clear) begin
      hcount     <= 13'h0000;
      line_len   <= 13'h0000;
      vcount     <= 13'h0000;
      seen_frame <= 1'b0;
      res_error  <= 1'b0;
    end else if (acc) begin
      if (frame_done)
        res_error <= size_bad;
      if (vid_sof) begin
        seen_frame <= 1'b1;
        vcount     <= 13'h0000;
        hcount     <= vid_eol ? 13'h0000 : 13'h0001;
      end else if (vid_eol) begin
        line_len <= hcount + 13'h0001;
        vcount   <= vcount + 13'h0001;
        hcount   <= 13'h0000;
      end else begin
        hcount <= hcount + 13'h0001;
      end
    end
  end

  // ==========================================================
  // rate conversion phase and latency total
  reg  [RATIO_W-1:0] frc_phase;
  reg  [7:0]         frc_frames;
  wire [7:0]         phase_w = {{(8-RATIO_W){1'b0}}, frc_phase};

  always @* begin
    case (src_kind)
      `VFD_KIND_ASYNC_UP: frc_frames = `VFD_FRC_FRAMES + phase_w;
      `VFD_KIND_ASYNC_DN: frc_frames = phase_w;
      default:            frc_frames = `VFD_FRC_FRAMES;
    endcase
  end

  wire async_kind = (src_kind == `VFD_KIND_ASYNC_UP) | (src_kind == `VFD_KIND_ASYNC_DN);
  wire [7:0] next_latency = dei_frames(src_kind) + frc_frames +
                            fmt_frames(src_kind, ratio_n, ratio_m);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frc_phase               <= {RATIO_W{1'b0}};
      latency_frames          <= 8'h00;
      deinterlacer_on         <= 1'b0;
      frame_rate_converter_on <= 1'b0;
      mode_error              <= 1'b0;
    end else begin
      if (sync_clear || !async_kind)
        frc_phase <= {RATIO_W{1'b0}};
      else if (frame_done)
        frc_phase <= (frc_phase >= ratio_n) ? {RATIO_W{1'b0}} : frc_phase + 1'b1;
      latency_frames          <= next_latency;
      deinterlacer_on         <= (dei_frames(src_kind) != 8'h00);
      frame_rate_converter_on <= async_kind;
      mode_error              <= (byte_mode != `VFD_BYTE_MODE_3 && byte_mode != `VFD_BYTE_MODE_4 &&
                                  byte_mode != `VFD_BYTE_MODE_5) | ~kind_ok(src_kind);
    end
  end

  // ==========================================================
  // pipeline fill: output waits until the first frame clears the stages
  reg [7:0] fill_count;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fill_count      <= 8'h00;
      video_live      <= 1'b0;
      out_frame_start <= 1'b0;
    end else if (sync_clear) begin
      fill_count      <= 8'h00;
      video_live      <= 1'b0;
      out_frame_start <= 1'b0;
    end else begin
      out_frame_start <= 1'b0;
      if (frame_done) begin
        if (fill_count != 8'hFF)
          fill_count <= fill_count + 8'h01;
        if (fill_count + 8'h01 >= latency_frames) begin
          video_live      <= 1'b1;
          out_frame_start <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // two-entry buffer: head drives the outputs, spare absorbs a stall
  reg  [31:0] spare;
  wire        keep = video_live & ~mode_error;
  wire        push = acc & keep;
  wire        pop  = pix_valid & pix_ready;
  wire [31:0] in_word = {vid_sof, vid_eol, trunc_data};

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pix_valid <= 1'b0;
      pix_data  <= 30'h00000000;
      pix_sof   <= 1'b0;
      pix_eol   <= 1'b0;
      spare     <= 32'h00000000;
      vid_ready <= 1'b0;
    end else if (sync_clear) begin
      pix_valid <= 1'b0;
      vid_ready <= 1'b1;
    end else begin
      if (!pix_valid || pop) begin
        if (!vid_ready) begin
          // after reset the spare is empty: hold ready low until a clear
          if (video_live) begin
            {pix_sof, pix_eol, pix_data} <= spare;
            pix_valid                    <= 1'b1;
            if (push)
              spare <= in_word;
            vid_ready <= ~push;
          end else begin
            pix_valid <= 1'b0;
            vid_ready <= 1'b0;
          end
        end else begin
          pix_valid <= push;
          if (push)
            {pix_sof, pix_eol, pix_data} <= in_word;
          vid_ready <= 1'b1;
        end
      end else if (push) begin
        spare     <= in_word;
        vid_ready <= 1'b0;
      end else if (vid_ready == 1'b0) begin
        vid_ready <= 1'b0;
      end else begin
        vid_ready <= 1'b1;
      end
    end
  end

endmodule // vfd_pipe

`default_nettype wire

// File: tb/vfd_pipe_monitor.sv
// concurrent checks on the frame delay pipeline ports
`timescale 1ns/100ps
`default_nettype none
module vfd_pipe_monitor #(parameter RATIO_W = 4) (
  input wire logic               mclk, rstn, sync_clear, vid_ready, pix_valid, pix_ready,
  input wire logic               deinterlacer_on, video_live, mode_error,
  input wire logic [2:0]         src_kind,
  input wire logic [1:0]         byte_mode,
  input wire logic [RATIO_W-1:0] ratio_n,
  input wire logic [29:0]        pix_data,
  input wire logic [7:0]         latency_frames
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========
  // latency, stage choice and stream checks
  AST_GFX: assert property (src_kind == 3'h1 |=> latency_frames == 8'h02)
    else $error("sync graphics latency wrong");
  AST_UPV: assert property (src_kind == 3'h3 |=> latency_frames == 8'h02 + $past(ratio_n))
    else $error("up-converted video latency wrong");
  AST_ASYNC: assert property (src_kind == 3'h0 |=> latency_frames > $past(ratio_n) &&
    latency_frames <= 8'h01 + 8'h02 * $past(ratio_n)) else $error("async latency out of range");
  AST_DEI: assert property (1'h1 |=> deinterlacer_on == ($past(src_kind) inside {3'h3, 3'h4}))
    else $error("deinterlacer choice wrong");
  AST_MODE: assert property (byte_mode == 2'h0 |=> mode_error)
    else $error("bad byte mode not flagged");
  AST_HOLD: assert property (pix_valid && !pix_ready && !sync_clear |=> pix_valid && $stable(pix_data))
    else $error("stalled output word changed");
  AST_LIVE: assert property (pix_valid |-> video_live)
    else $error("output before video is live");
  AST_CLEAR: assert property (sync_clear |=> !video_live && !pix_valid && vid_ready)
    else $error("clear did not empty the path");
  cover property (pix_valid && !pix_ready);
  cover property ($rose(video_live));
  cover property (src_kind == 3'h0 && latency_frames != 8'h00);
endmodule // vfd_pipe_monitor
`default_nettype wire

// File: tb/vfd_src.sv
// video source model driving the pixel stream
`timescale 1ns/100ps
`default_nettype none
module vfd_src (
  input  wire logic   mclk, vid_ready,
  output logic        vid_valid, vid_sof, vid_eol, hung,
  output logic [35:0] vid_data
);
  initial {vid_valid, vid_sof, vid_eol, hung, vid_data} = '0;
  // ==========
  // one word, held until ready is seen high at an edge
  // ready is read where it is settled, so its value is the one the edge samples
  task automatic put(input logic [35:0] d, input logic s, input logic e);
    int n;
    logic r;
    {vid_valid, vid_sof, vid_eol, vid_data} = {1'h1, s, e, d};
    r = vid_ready;
    @(posedge mclk);
    for (n = 1; n < 64 && r !== 1'h1; n++) begin
      #1;
      r = vid_ready;
      @(posedge mclk);
    end
    hung = (r !== 1'h1);
    #1;
  endtask
  // released data shows the inverse so a stale word is never read
  task automatic rel;
    {vid_valid, vid_sof, vid_eol} = 3'h0;
    vid_data = ~vid_data;
  endtask
endmodule // vfd_src
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the frame delay pipeline
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        mclk, rstn, sync_clear, deep_color, pix_ready, vid_valid, vid_ready, vid_sof, vid_eol;
  logic        hung, pix_valid, deinterlacer_on, video_live, res_error, mode_error;
  logic [2:0]  src_kind;
  logic [1:0]  byte_mode;
  logic [3:0]  ratio_n, ratio_m;
  logic [35:0] vid_data, a, b;
  logic [29:0] pix_data;
  logic [7:0]  latency_frames;
  int          error_cnt, samples_checked;
  vfd_pipe DUT (
    .mclk, .rstn, .sync_clear, .src_kind, .byte_mode, .deep_color, .ratio_n, .ratio_m, .vid_valid, .vid_ready,
    .vid_data, .vid_sof, .vid_eol, .pix_valid, .pix_ready, .pix_data, .pix_sof(), .pix_eol(), .latency_frames,
    .deinterlacer_on, .frame_rate_converter_on(), .video_live, .out_frame_start(), .res_error, .mode_error
  );
  vfd_src u_src (.mclk, .vid_ready, .vid_valid, .vid_sof, .vid_eol, .hung, .vid_data);
  // ==========
  // helpers and scenarios
  task chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task t_mode;
    for (int m = 0; m < 4; m++) begin
      byte_mode = m[1:0];
      tick(2);
      chk(mode_error, m == 0);
    end
  endtask
  task t_latency;
    logic [7:0] lo [6];
    logic [7:0] hi [6];
    lo = '{8'h01 + ratio_n, 8'h02, ratio_n, 8'h02 + ratio_n, 8'h03, 8'h01 + ratio_m};
    hi = '{8'h01 + 2 * ratio_n, 8'h02, 2 * ratio_n, 8'h02 + ratio_n, 8'h03, 8'h01 + ratio_m};
    for (int k = 0; k < 6; k++) begin
      src_kind = k[2:0];
      tick(2);
      chk(latency_frames >= lo[k] && latency_frames <= hi[k], 1);
      chk(deinterlacer_on, k == 3 || k == 4);
    end
  endtask
  task t_live;
    {src_kind, deep_color, pix_ready} = {3'h1, 1'h1, 1'h1};
    u_src.put(36'h0, 1'h1, 1'h1);
    u_src.put(36'h0, 1'h1, 1'h1);
    u_src.rel;
    tick(1);
    chk({video_live, res_error}, 1);
    u_src.put(36'h0, 1'h1, 1'h1);
    u_src.rel;
    tick(1);
    chk(video_live, 1);
    a = 36'hABCDEF123;
    u_src.put(a, 1'h0, 1'h1);
    chk({pix_valid, pix_data}, {1'h1, a[35:26], a[23:14], a[11:2]});
    u_src.rel;
    tick(1);
  endtask
  task t_stall;
    {pix_ready, deep_color, a} = {1'h0, 1'h0, 36'h123456789};
    b = ~a;
    u_src.put(a, 1'h0, 1'h0);
    u_src.put(b, 1'h0, 1'h0);
    u_src.rel;
    tick(1);
    chk({vid_ready, pix_data}, {1'h0, a[33:24], a[21:12], a[9:0]});
    pix_ready = 1'h1;
    tick(1);
    chk(pix_data, {b[33:24], b[21:12], b[9:0]});
    tick(1);
    chk({pix_valid, vid_ready}, 2'h1);
    pix_ready = 1'h0;
    u_src.put(a, 1'h0, 1'h0);
    sync_clear = 1'h1;
    tick(1);
    sync_clear = 1'h0;
    chk({video_live, pix_valid, vid_ready}, 3'h1);
    u_src.rel;
  endtask
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge hung) begin
    error_cnt++;
    stop_test;
  end
  initial begin
    {rstn, sync_clear, deep_color, pix_ready, src_kind, byte_mode} = {4'h0, 3'h1, 2'h1};
    {ratio_n, ratio_m} = {4'h3, 4'h2};
    tick(20);
    {rstn, sync_clear} = 2'h3;
    tick(1);
    sync_clear = 1'h0;
    t_mode;
    t_latency;
    t_live;
    t_stall;
    stop_test;
  end
endmodule // testbench
bind vfd_pipe vfd_pipe_monitor #(.RATIO_W(RATIO_W)) u_mon (
  .mclk, .rstn, .sync_clear, .vid_ready, .pix_valid, .pix_ready, .deinterlacer_on, .video_live,
  .mode_error, .src_kind, .byte_mode, .ratio_n, .pix_data, .latency_frames
);
`default_nettype wire
